//--- logic/sd_host_irq_mask_timeout_blocklen.sv
// interrupt mask, response and read-data time-outs, block length of the card host
// assumes an apb master on i_clk_sys and a card clock from another domain
`timescale 1ns/1ns
// Behaviour
// - response wait limit, zero disables
// - response expiry sets response time-out flag
// - response time-out interrupts when enabled
// - read wait is five high bits above low half
// - high read-wait part holds at most 1fh
// - read wait counts combined cycles, zero disables
// - read expiry sets read time-out flag
// - read time-out interrupts when enabled
// - block size field sets block byte count
// - bits 12, 11 enable done, dat3 edge
// - bits 10, 9 enable rx, tx ready
// - bits 7..5 enable crc error interrupts
// - bits 4, 3 enable time-out interrupts
// - bits 2..0 enable done interrupts
// - interrupt on status zero-to-one transition only
module sd_host_irq_mask_timeout_blocklen
    import sd_cfg_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [DATA_W-1:0] i_pwdata,
    output logic [DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_card_clk,
    input wire irq_bits_t i_events,
    input wire logic i_resp_wait_start,
    input wire logic i_resp_received,
    input wire logic i_rd_wait_start,
    input wire logic i_rd_data_received,
    input wire logic i_data_byte,
    input wire logic i_block_restart,
    output logic o_irq,
    output logic [BLOCK_SIZE_BYTES_W-1:0] o_block_size_bytes,
    output logic o_block_done
);

    apb_req_t req;
    logic access;
    logic wr_fire;
    logic rd_hit;
    logic status_wr;
    logic addr_ok;
    logic [DATA_W-1:0] rd_word;

    // apb handshake
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;

    // configuration
    irq_bits_t mask_reg;
    irq_bits_t mask_next;
    logic [RESP_CNT_W-1:0] resp_cnt_reg;
    logic [RESP_CNT_W-1:0] resp_cnt_next;
    logic [RD_HIGH_W-1:0] rd_high_reg;
    logic [RD_HIGH_W-1:0] rd_high_next;
    logic [RD_LOW_W-1:0] rd_low_reg;
    logic [RD_LOW_W-1:0] rd_low_next;
    logic [BLOCK_SIZE_BYTES_W-1:0] block_size_bytes_reg;
    logic [BLOCK_SIZE_BYTES_W-1:0] block_size_bytes_next;

    // events
    irq_bits_t status_reg;
    irq_bits_t status_next;
    irq_bits_t pending_reg;
    irq_bits_t pending_next;
    irq_bits_t ev_set;
    irq_bits_t ev_clr;
    irq_bits_t ev_rise;
    logic irq_reg;
    logic irq_next;

    // card clock sampling
    logic card_meta_reg;
    logic card_sync_reg;
    logic card_prev_reg;
    logic card_tick;

    // block byte counting
    logic [BLOCK_SIZE_BYTES_W-1:0] byte_cnt_reg;
    logic [BLOCK_SIZE_BYTES_W-1:0] byte_cnt_next;
    logic [BLOCK_SIZE_BYTES_W-1:0] byte_inc;
    logic last_byte;
    logic block_done_reg;
    logic block_done_next;

    // timers
    logic [RD_CNT_W-1:0] rd_limit;
    logic resp_active;
    logic resp_expired;
    logic rd_active;
    logic rd_expired;

    assign req.sel = i_psel;
    assign req.enable = i_penable;
    assign req.write = i_pwrite;
    assign req.addr = i_paddr;
    assign req.wdata = i_pwdata;

    // card clock passes two flops, then edge detect
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            card_meta_reg <= 1'b0;
            card_sync_reg <= 1'b0;
            card_prev_reg <= 1'b0;
        end else begin
            card_meta_reg <= i_card_clk;
            card_sync_reg <= card_meta_reg;
            card_prev_reg <= card_sync_reg;
        end
    end

    assign card_tick = card_sync_reg & ~card_prev_reg;

    // address decode and read mux
    always_comb begin
        access = req.sel & req.enable;
        wr_fire = access & pready_reg & req.write;
        rd_hit = access & ~pready_reg & ~req.write;
        status_wr = wr_fire & (req.addr == OFS_STATUS);
        addr_ok = 1'b1;
        rd_word = '0;
        case (req.addr)
            OFS_IRQ_MASK: begin
                rd_word[IRQ_W-1:0] = mask_reg & IRQ_VALID;
            end
            OFS_RESP_WAIT: begin
                rd_word[RESP_CNT_LSB +: RESP_CNT_W] = resp_cnt_reg;
                rd_word[RD_HIGH_LSB +: RD_HIGH_W] = rd_high_reg;
            end
            OFS_RD_WAIT: begin
                rd_word[RD_LOW_LSB +: RD_LOW_W] = rd_low_reg;
            end
            OFS_BLOCK_LEN: begin
                rd_word[BLOCK_SIZE_BYTES_LSB +: BLOCK_SIZE_BYTES_W] = block_size_bytes_reg;
            end
            OFS_STATUS: begin
                rd_word[IRQ_W-1:0] = status_reg;
            end
            OFS_PROGRESS: begin
                rd_word[BLOCK_SIZE_BYTES_W-1:0] = byte_cnt_reg;
                rd_word[PROG_RESP_ACT] = resp_active;
                rd_word[PROG_RD_ACT] = rd_active;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // one wait state, then ready with data
    always_comb begin
        pready_next = access & ~pready_reg;
        pslverr_next = access & ~pready_reg & ~addr_ok;
        prdata_next = prdata_reg;
        if (rd_hit) begin
            prdata_next = rd_word;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    // configuration writes
    always_comb begin
        mask_next = mask_reg;
        resp_cnt_next = resp_cnt_reg;
        rd_high_next = rd_high_reg;
        rd_low_next = rd_low_reg;
        block_size_bytes_next = block_size_bytes_reg;
        if (wr_fire) begin
            case (req.addr)
                OFS_IRQ_MASK: begin
                    mask_next = req.wdata[IRQ_W-1:0] & IRQ_VALID;
                end
                OFS_RESP_WAIT: begin
                    resp_cnt_next = req.wdata[RESP_CNT_LSB +: RESP_CNT_W];
                    // only five bits kept, top of range is 1fh
                    rd_high_next = req.wdata[RD_HIGH_LSB +: RD_HIGH_W];
                end
                OFS_RD_WAIT: begin
                    rd_low_next = req.wdata[RD_LOW_LSB +: RD_LOW_W];
                end
                OFS_BLOCK_LEN: begin
                    block_size_bytes_next = req.wdata[BLOCK_SIZE_BYTES_LSB +: BLOCK_SIZE_BYTES_W];
                end
                OFS_STATUS: begin
                    // write-one clear taken with the event bits
                    mask_next = mask_reg;
                end
                OFS_PROGRESS: begin
                    // read only, write dropped
                    mask_next = mask_reg;
                end
                default: begin
                    mask_next = mask_reg;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            mask_reg <= IRQ_MASK_RESET;
            resp_cnt_reg <= RESP_CNT_RESET;
            rd_high_reg <= RD_HIGH_RESET;
            rd_low_reg <= RD_LOW_RESET;
            block_size_bytes_reg <= BLOCK_SIZE_BYTES_RESET;
        end else begin
            mask_reg <= mask_next;
            resp_cnt_reg <= resp_cnt_next;
            rd_high_reg <= rd_high_next;
            rd_low_reg <= rd_low_next;
            block_size_bytes_reg <= block_size_bytes_next;
        end
    end

    // combined read wait count
    assign rd_limit = {{(RD_CNT_W-RD_HIGH_W-RD_LOW_W){1'b0}}, rd_high_reg, rd_low_reg};

    wait_timer #(
        .CNT_W(RESP_CNT_W)
    ) u_resp_timer (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_tick(card_tick),
        .i_start(i_resp_wait_start),
        .i_stop(i_resp_received),
        .i_limit(resp_cnt_reg),
        .o_active(resp_active),
        .o_expired(resp_expired)
    );

    wait_timer #(
        .CNT_W(RD_CNT_W)
    ) u_rd_timer (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_tick(card_tick),
        .i_start(i_rd_wait_start),
        .i_stop(i_rd_data_received),
        .i_limit(rd_limit),
        .o_active(rd_active),
        .o_expired(rd_expired)
    );

    // event sources and write-one clear
    always_comb begin
        ev_set = i_events & IRQ_VALID;
        ev_set.resp_timeout = resp_expired;
        ev_set.rd_timeout = rd_expired;
        ev_clr = '0;
        if (status_wr) begin
            ev_clr = req.wdata[IRQ_W-1:0] & IRQ_VALID;
        end
        // level interrupt from pending enabled events
        irq_next = |(pending_next & mask_next);
    end

    // sticky status and pending per event bit, set wins over clear
    for (genvar b = 0; b < IRQ_W; b++) begin : g_event_bit
        logic kept;
        // a bit cleared this cycle counts as zero
        assign kept = status_reg[b] & ~ev_clr[b];
        assign ev_rise[b] = ev_set[b] & ~kept;
        assign status_next[b] = kept | ev_set[b];
        assign pending_next[b] = (pending_reg[b] & ~ev_clr[b])
            | (ev_rise[b] & mask_reg[b]);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            status_reg <= '0;
            pending_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            pending_reg <= pending_next;
            irq_reg <= irq_next;
        end
    end

    // byte count per data block
    always_comb begin
        byte_cnt_next = byte_cnt_reg;
        block_done_next = 1'b0;
        byte_inc = byte_cnt_reg + {{(BLOCK_SIZE_BYTES_W-1){1'b0}}, 1'b1};
        // zero block length acts as one byte
        last_byte = (byte_inc >= block_size_bytes_reg);
        if (i_block_restart) begin
            byte_cnt_next = '0;
        end else if (i_data_byte) begin
            if (last_byte) begin
                byte_cnt_next = '0;
                block_done_next = 1'b1;
            end else begin
                byte_cnt_next = byte_inc;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            byte_cnt_reg <= '0;
            block_done_reg <= 1'b0;
        end else begin
            byte_cnt_reg <= byte_cnt_next;
            block_done_reg <= block_done_next;
        end
    end

    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_irq = irq_reg;
    assign o_block_size_bytes = block_size_bytes_reg;
    assign o_block_done = block_done_reg;

endmodule

//--- logic/sd_cfg_pkg.sv
// constants, register map and field layouts of the card host config slice
// assumes a 32-bit apb master and a card clock far slower than the system clock
package sd_cfg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RESP_WAIT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RD_WAIT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_BLOCK_LEN = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PROGRESS = 8'h14;

    // field positions and widths
    localparam int RESP_CNT_LSB = 0;
    localparam int RESP_CNT_W = 8;
    localparam int RD_HIGH_LSB = 8;
    localparam int RD_HIGH_W = 5;
    localparam int RD_LOW_LSB = 0;
    localparam int RD_LOW_W = 16;
    localparam int RD_CNT_W = 24;
    localparam int BLOCK_SIZE_BYTES_LSB = 0;
    localparam int BLOCK_SIZE_BYTES_W = 12;
    localparam int IRQ_W = 13;
    localparam int PROG_RESP_ACT = 16;
    localparam int PROG_RD_ACT = 17;

    // values after reset
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 13'h0000;
    localparam logic [RESP_CNT_W-1:0] RESP_CNT_RESET = 8'h00;
    localparam logic [RD_HIGH_W-1:0] RD_HIGH_RESET = 5'h00;
    localparam logic [RD_LOW_W-1:0] RD_LOW_RESET = 16'h0000;
    localparam logic [BLOCK_SIZE_BYTES_W-1:0] BLOCK_SIZE_BYTES_RESET = 12'h200;

    // implemented event bits, bit 8 reserved
    localparam logic [IRQ_W-1:0] IRQ_VALID = 13'h1eff;

    // event layout shared by mask, status and event inputs
    typedef struct packed {
        logic xfer_finished;
        logic dat3_edge;
        logic rx_reg_ready;
        logic tx_reg_ready;
        logic reserved8;
        logic resp_crc_err;
        logic rd_crc_err;
        logic wr_crc_err;
        logic resp_timeout;
        logic rd_timeout;
        logic cmd_resp_finished;
        logic busy_release;
        logic data_finished;
    } irq_bits_t;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } apb_req_t;

endpackage

//--- logic/wait_timer.sv
// card clock cycle wait counter with a programmable limit
// assumes start, stop and tick are single-cycle pulses on the system clock
`timescale 1ns/1ns
module wait_timer #(
    parameter int CNT_W = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_tick,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic [CNT_W-1:0] i_limit,
    output logic o_active,
    output logic o_expired
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] limit_reg;
    logic [CNT_W-1:0] limit_next;
    logic active_reg;
    logic active_next;
    logic expired_reg;
    logic expired_next;
    logic [CNT_W-1:0] cnt_inc;

    always_comb begin
        cnt_next = cnt_reg;
        limit_next = limit_reg;
        active_next = active_reg;
        expired_next = 1'b0;
        cnt_inc = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        if (i_start) begin
            cnt_next = '0;
            limit_next = i_limit;
            // zero limit means no time-out at all
            active_next = (i_limit != '0);
        end else if (i_stop) begin
            active_next = 1'b0;
        end else if (active_reg && i_tick) begin
            cnt_next = cnt_inc;
            if (cnt_inc == limit_reg) begin
                active_next = 1'b0;
                expired_next = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            cnt_reg <= '0;
            limit_reg <= '0;
            active_reg <= 1'b0;
            expired_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            limit_reg <= limit_next;
            active_reg <= active_next;
            expired_reg <= expired_next;
        end
    end

    assign o_active = active_reg;
    assign o_expired = expired_reg;

endmodule

//--- test/sd_host_cfg_properties.sv
// port assertions of the card host config slice
// assumes a bind onto sd_host_irq_mask_timeout_blocklen
`timescale 1ns/1ns
module sd_host_cfg_checker
    import sd_cfg_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [DATA_W-1:0] i_pwdata,
    input wire logic [DATA_W-1:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_data_byte,
    input wire logic o_irq,
    input wire logic [BLOCK_SIZE_BYTES_W-1:0] o_block_size_bytes,
    input wire logic o_block_done
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    logic acc;
    logic wr;
    assign acc = i_psel && i_penable && o_pready;
    assign wr = acc && i_pwrite;
    a_ready_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("ready late");
    a_ready_one_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready held");
    a_unmapped_err: assert property (acc && i_paddr > OFS_PROGRESS |-> o_pslverr)
        else $error("no error on unmapped");
    a_err_data_zero: assert property (o_pslverr && !i_pwrite |-> o_prdata == '0)
        else $error("error read not zero");
    a_block_size_bytes_reset_val: assert property ($rose(i_resetn) |-> o_block_size_bytes == BLOCK_SIZE_BYTES_RESET)
        else $error("block length reset");
    a_block_size_bytes_from_write: assert property (!$stable(o_block_size_bytes) |->
        $past(wr && i_paddr == OFS_BLOCK_LEN) && o_block_size_bytes == $past(i_pwdata[11:0]))
        else $error("block length changed alone");
    a_done_from_byte: assert property (o_block_done |-> $past(i_data_byte))
        else $error("done without byte");
    a_irq_fall_write: assert property ($fell(o_irq) |-> $past(wr) || $past(wr, 2))
        else $error("irq fell without write");
endmodule

bind sd_host_irq_mask_timeout_blocklen sd_host_cfg_checker i_chk (.i_clk_sys, .i_resetn,
    .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_data_byte, .o_irq, .o_block_size_bytes, .o_block_done);

//--- test/card_model.sv
// card model: card clock bursts, edge count, reply after a set edge count
// assumes the bench raises i_run for each wait and lowers it between
`timescale 1ns/1ns
module card_model (
    input wire logic i_clk_sys,
    input wire logic i_run,
    input wire logic [15:0] i_reply_after,
    output logic o_card_clk,
    output logic [15:0] o_edges,
    output logic o_reply
);
    logic clk_d;
    initial o_card_clk = 1'b0;
    // clock stands low outside a burst
    always #80 o_card_clk = i_run ? !o_card_clk : 1'b0;
    always @(posedge i_clk_sys) begin
        clk_d <= o_card_clk;
        if (!i_run) o_edges <= '0;
        else if (o_card_clk && !clk_d) o_edges <= o_edges + 16'h1;
        // zero means no reply, the host side must time out
        o_reply <= i_run && i_reply_after != 0 && o_card_clk && !clk_d
            && o_edges + 16'h1 == i_reply_after;
    end
endmodule

//--- test/tb_top.sv
// self-checking bench of the card host config slice
// assumes the card model and the port checker beside the design
`timescale 1ns/1ns
module tb_top import sd_cfg_pkg::*;;
    localparam int BLK = 3;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, run = 0, rstart = 0, dstart = 0;
    logic dbyte = 0, restart = 0, ready, err, irq, done, reply, card_clk;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [DATA_W-1:0] rdata;
    logic [BLOCK_SIZE_BYTES_W-1:0] block_size_bytes;
    logic [15:0] reply_after = '0;
    logic [15:0] edges;
    irq_bits_t ev = '0;
    int error_cnt = 0;
    int checks = 0;
    logic [32:0] exp_q[$];
    logic [31:0] seed = 32'h2b53;
    sd_host_irq_mask_timeout_blocklen i_dut (.i_clk_sys(clk), .i_resetn(rstn), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .o_prdata(rdata),
        .o_pready(ready), .o_pslverr(err), .i_card_clk(card_clk), .i_events(ev),
        .i_resp_wait_start(rstart), .i_resp_received(reply), .i_rd_wait_start(dstart),
        .i_rd_data_received(reply), .i_data_byte(dbyte), .i_block_restart(restart),
        .o_irq(irq), .o_block_size_bytes(block_size_bytes), .o_block_done(done));
    card_model i_card (.i_clk_sys(clk), .i_run(run), .i_reply_after(reply_after),
        .o_card_clk(card_clk), .o_edges(edges), .o_reply(reply));
    initial forever #5 clk = !clk;
    task automatic complete_run;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] e);
        int n;
        if (!w) exp_q.push_back(e);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!ready && n < 20);
        psel <= 0;
        pen <= 0;
        if (!ready) begin
            error_cnt++;
            complete_run();
        end
    endtask
    always @(posedge clk) begin
        if (ready && !pwr) chk({err, rdata}, exp_q.pop_front());
    end
    task automatic timeout_run(input logic rd, input int lim, input int rep, input logic exp);
        int n;
        apb(1, rd ? OFS_RD_WAIT : OFS_RESP_WAIT, lim, 0);
        apb(1, OFS_IRQ_MASK, rd ? 32'h8 : 32'h10, 0);
        reply_after <= 16'(rep);
        rstart <= !rd;
        dstart <= rd;
        @(posedge clk);
        rstart <= 0;
        dstart <= 0;
        run <= 1;
        n = 0;
        while (!irq && edges < lim + 3 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000) begin
            error_cnt++;
            complete_run();
        end
        chk(irq, exp);
        if (exp) chk(edges, lim);
        run <= 0;
        apb(0, OFS_STATUS, 0, exp ? (rd ? 33'h8 : 33'h10) : 33'h0);
        apb(1, OFS_STATUS, 32'h18, 0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1;
        apb(0, OFS_IRQ_MASK, 0, 0);
        apb(0, OFS_RD_WAIT, 0, 0);
        apb(0, OFS_BLOCK_LEN, 0, 33'h200);
        apb(0, 8'h18, 0, 33'h1_0000_0000);
        apb(1, 8'h1c, 32'h1, 0);
        apb(1, OFS_IRQ_MASK, 32'hffff_ffff, 0);
        apb(0, OFS_IRQ_MASK, 0, 33'h1eff);
        apb(1, OFS_RESP_WAIT, 32'hffff_ffff, 0);
        apb(0, OFS_RESP_WAIT, 0, 33'h1fff);
        apb(1, OFS_RD_WAIT, 32'hffff_ffff, 0);
        apb(0, OFS_RD_WAIT, 0, 33'hffff);
        for (int i = 0; i < IRQ_W; i++) begin
            if (IRQ_VALID[i] && i != 3 && i != 4) begin
                apb(1, OFS_IRQ_MASK, 1 << i, 0);
                ev <= irq_bits_t'(1 << i);
                @(posedge clk);
                ev <= '0;
                repeat (2) @(posedge clk);
                chk(irq, 1);
                apb(1, OFS_STATUS, 1 << i, 0);
                repeat (2) @(posedge clk);
                chk(irq, 0);
            end
        end
        apb(1, OFS_IRQ_MASK, 0, 0);
        ev <= irq_bits_t'(13'h1);
        @(posedge clk);
        ev <= '0;
        apb(1, OFS_IRQ_MASK, 1, 0);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        apb(0, OFS_STATUS, 0, 33'h1);
        apb(1, OFS_STATUS, 1, 0);
        seed = lfsr(seed);
        timeout_run(0, 1 + seed[2:0], 0, 1);
        timeout_run(0, 255, 0, 1);
        timeout_run(0, 0, 0, 0);
        timeout_run(0, 6, 2, 0);
        seed = lfsr(seed);
        timeout_run(1, 1 + seed[3:0], 0, 1);
        timeout_run(1, 0, 0, 0);
        timeout_run(1, 6, 2, 0);
        apb(1, OFS_RESP_WAIT, 32'h100, 0);
        apb(1, OFS_RD_WAIT, 0, 0);
        dstart <= 1;
        @(posedge clk);
        dstart <= 0;
        apb(0, OFS_PROGRESS, 0, 33'h2_0000);
        apb(1, OFS_BLOCK_LEN, BLK, 0);
        @(posedge clk);
        chk(block_size_bytes, BLK);
        dbyte <= 1;
        @(posedge clk);
        dbyte <= 0;
        restart <= 1;
        @(posedge clk);
        restart <= 0;
        for (int k = 1; k <= BLK; k++) begin
            dbyte <= 1;
            @(posedge clk);
            dbyte <= 0;
            @(posedge clk);
            chk(done, k == BLK);
        end
        complete_run();
    end
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
endmodule
